// [inc/text_display_pkg.sv]
// shared constants, types and register map of the text display selector
package text_display_pkg;
  // register byte offsets
  localparam logic [5:0] CTRL_OFF     = 6'h00;
  localparam logic [5:0] COIL_OFF     = 6'h04;
  localparam logic [5:0] RETAIN_OFF   = 6'h08;
  localparam logic [5:0] SHOW_OFF     = 6'h0c;
  localparam logic [5:0] TXT_ADDR_OFF = 6'h10;
  localparam logic [5:0] TXT_DATA_OFF = 6'h14;
  localparam logic [5:0] SETPT_OFF    = 6'h18;
  localparam logic [5:0] SCALED_OFF   = 6'h1c;
  // text store geometry
  localparam int NUM_TEXTS  = 16;
  localparam int NUM_RETAIN = 8;
  localparam int LINE_CHARS = 12;
  localparam int TEXT_CHARS = 4 * LINE_CHARS;
  localparam int MEM_DEPTH  = NUM_TEXTS * TEXT_CHARS;
  localparam logic [7:0] SPACE_CHAR = 8'h20;
  // timebase
  localparam int CLK_HZ        = 20_000_000;
  localparam int SEC_S         = 1;
  localparam int SEC_CYCLES    = CLK_HZ * SEC_S;
  localparam int ROTATE_S      = 4;
  localparam logic [2:0] ROTATE_TICKS = 3'(ROTATE_S / SEC_S);
  // analog scaling: full-scale code, span and offset per range
  localparam int ADC_FULL   = 1023;
  localparam int UNI_SPAN   = 9999;
  localparam int BI_SPAN    = 1998;
  localparam int BI_OFS     = 999;
  localparam int TENTH_SPAN = 198;
  localparam int TENTH_OFS  = 99;
  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // reset values
  localparam logic [5:0] CTRL_RESET = 6'h04;
  typedef enum logic [1:0] {SCALE_UNIPOLAR, SCALE_BIPOLAR, SCALE_TENTHS} scale_type;
  typedef struct packed {
    scale_type  scale;
    logic       sp_edit;
    logic       power_ok;
    logic       status_view;
    logic       run;
  } ctrl_type;
  typedef struct packed {
    logic       rotating;
    logic       alarm;
    logic       on;
    logic [3:0] slot;
  } show_type;
  typedef struct packed {
    logic        valid;
    logic        line3;
    logic [3:0]  slot;
    logic [15:0] value;
  } setpoint_type;
endpackage

// [verilog/text_store.sv]
// text character memory, one byte per display position
`timescale 1ns/1ps
module text_store
  import text_display_pkg::*;
(
  // clock
  input  wire logic       aclk,
  // write side
  input  wire logic       we,
  input  wire logic [9:0] waddr,
  input  wire logic [7:0] wdata,
  // read side
  input  wire logic [9:0] raddr,
  output logic      [7:0] rdata
);
  logic [7:0] mem [MEM_DEPTH];

  // write port
  always_ff @(posedge aclk) begin
    if (we && (32'(waddr) < MEM_DEPTH)) begin
      mem[waddr] <= wdata;
    end
  end

  // registered read port
  always_ff @(posedge aclk) begin
    rdata <= (32'(raddr) < MEM_DEPTH) ? mem[raddr] : SPACE_CHAR;
  end
endmodule

// [verilog/analog_scaler.sv]
// scales a 0 to 10 v analog code into one of three display ranges
`timescale 1ns/1ps
module analog_scaler
  import text_display_pkg::*;
(
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // range and sample
  input  wire text_display_pkg::scale_type mode,
  input  wire logic [9:0]        adc_value,
  // scaled result
  output logic signed [15:0]     scaled
);
  // rounded linear map raw*span/full - offset
  function automatic logic signed [15:0] scale_to(input logic [9:0] raw,
                                                  input int span, input int ofs);
    int v;
    v = (int'(raw) * span + ADC_FULL / 2) / ADC_FULL - ofs;
    return 16'(v);
  endfunction

  // select range and register result
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scaled <= 16'sh0000;
    end else begin
      case (mode)
        SCALE_BIPOLAR: scaled <= scale_to(adc_value, BI_SPAN, BI_OFS);
        SCALE_TENTHS:  scaled <= scale_to(adc_value, TENTH_SPAN, TENTH_OFS);
        default:       scaled <= scale_to(adc_value, UNI_SPAN, 0);
      endcase
    end
  end
endmodule

// [verilog/text_display_selector.sv]
// text display selector: trigger coils, alarm priority, rotation, axi regs
//
// Overview of operation
// - sixteen stored texts, each with coil and contact
// - coil at one requests its text
// - show only in run with status view
// - contact reads back the coil like a marker
// - several ordinary texts rotate every 4 s
// - rotation stops on stop, power, menu, alarm, edit
// - slot one alarm text overrides rotation
// - alarm holds until coil, stop, power, menu
// - slots one to eight optionally retentive
// - retentive coils resume on restart in run
// - four lines of twelve characters
// - setpoints editable only while text shown
// - analog value scaled into three ranges
//
// Added by the designer: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module text_display_selector
  import text_display_pkg::*;
#(
  parameter int TICK_CYCLES = SEC_CYCLES
)(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write
  input  wire logic [5:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // axi4-lite read
  input  wire logic [5:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // operator buttons
  input  wire logic        ok_button,
  input  wire logic        delete_button,
  input  wire logic        alternate_button,
  // analog input
  input  wire logic [9:0]  adc_value,
  // character display
  input  wire logic [5:0]  disp_pos,
  output logic [7:0]       disp_char,
  output text_display_pkg::show_type show,
  output logic [15:0]      contact,
  output logic signed [15:0] scaled_value,
  output text_display_pkg::setpoint_type setpoint
);
  import text_display_pkg::*;

  typedef enum logic [1:0] {IDLE, ALARM, ROTATE} state_type;

  ctrl_type         ctrl_reg;
  logic [15:0]      coil_reg;
  logic [7:0]       retain_reg;
  logic [9:0]       txt_addr_reg;
  state_type        state_reg, state_next;
  logic [3:0]       slot_reg, slot_next;
  logic             aw_have_reg, w_have_reg;
  logic [5:0]       awaddr_reg;
  logic [31:0]      wdata_reg;
  logic [3:0]       wstrb_reg;
  logic [2:0]       btn_meta_reg, btn_sync_reg;
  logic             menu_prev_reg, run_prev_reg, pwr_prev_reg;
  logic [31:0]      tick_cnt_reg;
  logic [2:0]       rot_cnt_reg;
  logic             pos_ok_reg;
  logic [7:0]       mem_rdata;
  logic             do_write, menu_evt, act, sec_tick, rot_tick, stop_evt;
  logic [15:0]      ord_mask;

  // next set ordinary slot above cur, wrapping; cur if none
  function automatic logic [3:0] next_slot(input logic [15:0] mask, input logic [3:0] cur);
    logic [3:0] s;
    next_slot = cur;
    for (int i = 15; i >= 1; i--) begin
      s = cur + 4'(i);
      if (mask[s]) begin
        next_slot = s;
      end
    end
  endfunction

  // byte-lane merge of a write
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    merge = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        merge[8*b +: 8] = nw[8*b +: 8];
      end
    end
  endfunction

  // write channel handshakes
  assign awready  = !aw_have_reg;
  assign wready   = !w_have_reg;
  assign do_write = aw_have_reg && w_have_reg && !bvalid;
  assign arready  = !rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg <= 1'b0;
      w_have_reg  <= 1'b0;
      awaddr_reg  <= 6'h00;
      wdata_reg   <= 32'h0000_0000;
      wstrb_reg   <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        aw_have_reg <= 1'b1;
        awaddr_reg  <= awaddr;
      end else if (do_write) begin
        aw_have_reg <= 1'b0;
      end
      if (wvalid && wready) begin
        w_have_reg <= 1'b1;
        wdata_reg  <= wdata;
        wstrb_reg  <= wstrb;
      end else if (do_write) begin
        w_have_reg <= 1'b0;
      end
    end
  end

  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else if (do_write) begin
      bvalid <= 1'b1;
      case (awaddr_reg)
        CTRL_OFF, COIL_OFF, RETAIN_OFF, TXT_ADDR_OFF, TXT_DATA_OFF: bresp <= RESP_OKAY;
        SETPT_OFF: bresp <= (state_reg != IDLE && ctrl_reg.sp_edit) ? RESP_OKAY : RESP_SLVERR;
        default:   bresp <= RESP_SLVERR;
      endcase
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // button synchronisers, then menu edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      btn_meta_reg  <= 3'h0;
      btn_sync_reg  <= 3'h0;
      menu_prev_reg <= 1'b0;
    end else begin
      btn_meta_reg  <= {ok_button, delete_button, alternate_button};
      btn_sync_reg  <= btn_meta_reg;
      menu_prev_reg <= btn_sync_reg[2] || (btn_sync_reg[1] && btn_sync_reg[0]);
    end
  end
  assign menu_evt = (btn_sync_reg[2] || (btn_sync_reg[1] && btn_sync_reg[0])) && !menu_prev_reg;

  // control register; menu entry drops the status view
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= ctrl_type'(CTRL_RESET);
    end else begin
      if (do_write && awaddr_reg == CTRL_OFF) begin
        ctrl_reg <= ctrl_type'(6'(merge({26'h0, ctrl_reg}, wdata_reg, wstrb_reg)));
      end
      if (menu_evt) begin
        ctrl_reg.status_view <= 1'b0;
      end
    end
  end

  // stop or power loss edges
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_prev_reg <= 1'b0;
      pwr_prev_reg <= 1'b1;
    end else begin
      run_prev_reg <= ctrl_reg.run;
      pwr_prev_reg <= ctrl_reg.power_ok;
    end
  end
  assign stop_evt = (run_prev_reg && !ctrl_reg.run) || (pwr_prev_reg && !ctrl_reg.power_ok);

  // trigger coils behave as markers; retentive ones survive stop
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      coil_reg   <= 16'h0000;
      retain_reg <= 8'h00;
    end else begin
      if (do_write && awaddr_reg == RETAIN_OFF) begin
        retain_reg <= 8'(merge({24'h0, retain_reg}, wdata_reg, wstrb_reg));
      end
      if (stop_evt) begin
        coil_reg <= {8'h00, coil_reg[7:0] & retain_reg};
      end else if (do_write && awaddr_reg == COIL_OFF && ctrl_reg.run) begin
        coil_reg <= 16'(merge({16'h0, coil_reg}, wdata_reg, wstrb_reg));
      end
    end
  end
  assign contact = coil_reg;

  // text store address and setpoint entry
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      txt_addr_reg <= 10'h000;
      setpoint     <= '0;
    end else begin
      setpoint.valid <= 1'b0;
      if (do_write && awaddr_reg == TXT_ADDR_OFF) begin
        txt_addr_reg <= wdata_reg[9:0];
      end else if (do_write && awaddr_reg == TXT_DATA_OFF) begin
        txt_addr_reg <= txt_addr_reg + 10'h001;
      end
      if (do_write && awaddr_reg == SETPT_OFF && state_reg != IDLE && ctrl_reg.sp_edit) begin
        setpoint <= {1'b1, wdata_reg[16], slot_reg, wdata_reg[15:0]};
      end
    end
  end

  // seconds timebase and 4 s rotation count
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt_reg <= 32'h0000_0000;
      rot_cnt_reg  <= 3'h0;
    end else begin
      tick_cnt_reg <= sec_tick ? 32'h0000_0000 : tick_cnt_reg + 32'h0000_0001;
      if (state_reg != ROTATE || slot_next != slot_reg || ctrl_reg.sp_edit) begin
        rot_cnt_reg <= 3'h0;
      end else if (sec_tick) begin
        rot_cnt_reg <= rot_tick ? 3'h0 : rot_cnt_reg + 3'h1;
      end
    end
  end
  assign sec_tick = tick_cnt_reg == 32'(TICK_CYCLES - 1);
  assign rot_tick = sec_tick && rot_cnt_reg == ROTATE_TICKS - 3'h1;

  assign act      = ctrl_reg.run && ctrl_reg.power_ok && ctrl_reg.status_view;
  assign ord_mask = {coil_reg[15:1], 1'b0};

  // display selection
  always_comb begin
    state_next = state_reg;
    slot_next  = slot_reg;
    if (!act || menu_evt) begin
      state_next = IDLE;
    end else if (coil_reg[0]) begin
      state_next = ALARM;
      slot_next  = 4'h0;
    end else if (ord_mask == 16'h0000) begin
      state_next = IDLE;
    end else if (state_reg != ROTATE) begin
      state_next = ROTATE;
      slot_next  = next_slot(ord_mask, 4'h0);
    end else if (!ord_mask[slot_reg] || (rot_tick && !ctrl_reg.sp_edit)) begin
      slot_next = next_slot(ord_mask, slot_reg);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= IDLE;
      slot_reg  <= 4'h0;
    end else begin
      state_reg <= state_next;
      slot_reg  <= slot_next;
    end
  end

  always_comb begin
    show.rotating = state_reg == ROTATE;
    show.alarm    = state_reg == ALARM;
    show.on       = state_reg != IDLE;
    show.slot     = slot_reg;
  end

  // character fetch: 4 lines of 12 per text
  text_store i_text_store (
    .aclk  (aclk),
    .we    (do_write && awaddr_reg == TXT_DATA_OFF),
    .waddr (txt_addr_reg),
    .wdata (wdata_reg[7:0]),
    .raddr (10'(32'(slot_reg) * TEXT_CHARS + 32'(disp_pos))),
    .rdata (mem_rdata)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pos_ok_reg <= 1'b0;
      disp_char  <= SPACE_CHAR;
    end else begin
      pos_ok_reg <= show.on && 32'(disp_pos) < TEXT_CHARS;
      disp_char  <= pos_ok_reg ? mem_rdata : SPACE_CHAR;
    end
  end

  analog_scaler i_analog_scaler (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .mode      (ctrl_reg.scale),
    .adc_value (adc_value),
    .scaled    (scaled_value)
  );

  // register reads
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp  <= RESP_OKAY;
      case (araddr)
        CTRL_OFF:     rdata <= {26'h0, ctrl_reg};
        COIL_OFF:     rdata <= {16'h0, coil_reg};
        RETAIN_OFF:   rdata <= {24'h0, retain_reg};
        SHOW_OFF:     rdata <= {25'h0, show};
        TXT_ADDR_OFF: rdata <= {22'h0, txt_addr_reg};
        TXT_DATA_OFF: rdata <= 32'h0000_0000;
        SETPT_OFF:    rdata <= {15'h0, setpoint.line3, setpoint.value};
        SCALED_OFF:   rdata <= {16'h0, scaled_value};
        default: begin
          rdata <= 32'h0000_0000;
          rresp <= RESP_SLVERR;
        end
      endcase
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // checks
  property p_alarm_wins;
    @(posedge aclk) disable iff (!aresetn)
    act && !menu_evt && coil_reg[0] |=> show.alarm && show.slot == 4'h0;
  endproperty
  a_alarm_wins: assert property (p_alarm_wins) else $error("alarm not shown");

  property p_alarm_release;
    @(posedge aclk) disable iff (!aresetn)
    show.alarm && !coil_reg[0] |=> !show.alarm;
  endproperty
  a_alarm_release: assert property (p_alarm_release) else $error("alarm held");

  property p_needs_run;
    @(posedge aclk) disable iff (!aresetn)
    !ctrl_reg.run |=> !show.on;
  endproperty
  a_needs_run: assert property (p_needs_run) else $error("shown while stopped");

  property p_contact;
    @(posedge aclk) disable iff (!aresetn)
    do_write && awaddr_reg == COIL_OFF && ctrl_reg.run && !stop_evt && wstrb_reg == 4'hf
      |=> contact == $past(wdata_reg[15:0]);
  endproperty
  a_contact: assert property (p_contact) else $error("contact mismatch");

  property p_retain;
    @(posedge aclk) disable iff (!aresetn)
    $fell(ctrl_reg.run) |=> coil_reg[15:8] == 8'h00
      && coil_reg[7:0] == ($past(coil_reg[7:0]) & $past(retain_reg));
  endproperty
  a_retain: assert property (p_retain) else $error("retention wrong");

  property p_rotate;
    @(posedge aclk) disable iff (!aresetn)
    show.rotating && rot_tick && act && !menu_evt && !coil_reg[0] && !ctrl_reg.sp_edit
      && $countones(ord_mask) > 1 |=> show.slot != $past(slot_reg) && show.rotating;
  endproperty
  a_rotate: assert property (p_rotate) else $error("no rotation step");

  property p_menu;
    @(posedge aclk) disable iff (!aresetn)
    menu_evt |=> !show.on ##1 !ctrl_reg.status_view;
  endproperty
  a_menu: assert property (p_menu) else $error("menu did not end display");

  property p_setpoint;
    @(posedge aclk) disable iff (!aresetn)
    do_write && awaddr_reg == SETPT_OFF && !show.on |=> !setpoint.valid && bresp == RESP_SLVERR;
  endproperty
  a_setpoint: assert property (p_setpoint) else $error("setpoint taken");
endmodule

// [tb/display_panel.sv]
// operator panel model: character scan and push buttons
`timescale 1ns/1ps
module display_panel (
  // clock
  input  wire logic       aclk,
  // bench requests: position to scan, 1 = ok, 2 = delete plus alternate
  input  wire logic [5:0] want_pos,
  input  wire logic [1:0] press,
  // device side
  input  wire logic [7:0] disp_char,
  output logic      [5:0] disp_pos,
  output logic            ok_button,
  output logic            delete_button,
  output logic            alternate_button,
  // character as the panel latched it
  output logic      [7:0] seen_char
);
  // scan position and latch what comes back
  always_ff @(posedge aclk) begin
    disp_pos  <= want_pos;
    seen_char <= disp_char;
  end
  // released buttons fall back low
  always_ff @(posedge aclk) begin
    ok_button        <= (press == 2'd1);
    delete_button    <= (press == 2'd2);
    alternate_button <= (press == 2'd2);
  end
endmodule

// [tb/text_display_selector_bench.sv]
// self-checking bench for the text display selector
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
  $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module text_display_selector_bench;
  import text_display_pkg::*;
  localparam int TICK = 10;
  logic               aclk, aresetn;
  logic        [5:0]  awaddr, araddr, disp_pos, want_pos;
  logic        [31:0] wdata, rdata;
  logic        [3:0]  wstrb;
  logic        [1:0]  bresp, rresp, press;
  logic               awvalid, awready, wvalid, wready, bvalid, bready;
  logic               arvalid, arready, rvalid, rready;
  logic               ok_b, del_b, alt_b;
  logic        [9:0]  adc_value;
  logic        [7:0]  disp_char, seen_char;
  show_type           show;
  setpoint_type       setpoint;
  logic        [15:0] contact;
  logic signed [15:0] scaled_value;
  int                 error_cnt, checks_done, n;

  text_display_selector #(.TICK_CYCLES(TICK)) i_text_display_selector (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .ok_button(ok_b), .delete_button(del_b), .alternate_button(alt_b),
    .adc_value(adc_value), .disp_pos(disp_pos), .disp_char(disp_char), .show(show),
    .contact(contact), .scaled_value(scaled_value), .setpoint(setpoint));
  display_panel i_display_panel (
    .aclk(aclk), .want_pos(want_pos), .press(press), .disp_char(disp_char),
    .disp_pos(disp_pos), .ok_button(ok_b), .delete_button(del_b),
    .alternate_button(alt_b), .seen_char(seen_char));

  // clock
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  task automatic settle(input int c);
    repeat (c) @(posedge aclk);
  endtask

  // axi4-lite write, both channels offered together
  task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [1:0] r;
    r = 2'bxx;
    @(posedge aclk);
    awaddr <= a; wdata <= d; wstrb <= 4'hf;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        r = bresp; bready <= 1'b0; break;
      end
    end
    `CHK(r, er)
  endtask

  // axi4-lite read
  task automatic rd(input logic [5:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    d = 'x; r = 2'bxx;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        d = rdata; r = rresp; rready <= 1'b0; break;
      end
    end
    `CHK(d, ed)
    `CHK(r, er)
  endtask

  // cycles until the shown slot moves
  task automatic wait_chg(output int c);
    logic [3:0] s;
    s = show.slot;
    c = 0;
    while (show.slot === s && c < 200) begin
      @(posedge aclk); c++;
    end
  endtask

  task automatic t_reset;
    rd(CTRL_OFF, 32'h0000_0004, RESP_OKAY);
    rd(SHOW_OFF, 32'h0, RESP_OKAY);
    rd(6'h20, 32'h0, RESP_SLVERR);
    `CHK(disp_char, 8'h20)
  endtask

  task automatic t_gate;
    wr(COIL_OFF, 32'h4, RESP_OKAY);
    rd(COIL_OFF, 32'h0, RESP_OKAY);
    wr(CTRL_OFF, 32'h05, RESP_OKAY);
    wr(COIL_OFF, 32'h4, RESP_OKAY);
    settle(3);
    `CHK(show.on, 1'b0)
    `CHK(contact, 16'h0004)
    wr(COIL_OFF, 32'h0, RESP_OKAY);
    wr(CTRL_OFF, 32'h07, RESP_OKAY);
    wr(COIL_OFF, 32'h4, RESP_OKAY);
    settle(2);
    `CHK(show, 7'h52)
  endtask

  task automatic t_rotate;
    wr(COIL_OFF, 32'h0, RESP_OKAY);
    wr(COIL_OFF, 32'h000a, RESP_OKAY);
    settle(2);
    `CHK(show, 7'h51)
    wait_chg(n);
    `CHK(show.slot, 4'h3)
    wait_chg(n);
    `CHK(n, 4 * TICK)
    `CHK(show.slot, 4'h1)
  endtask

  task automatic t_alarm;
    wr(COIL_OFF, 32'h1, RESP_OKAY);
    settle(2);
    wr(COIL_OFF, 32'h0, RESP_OKAY);
    settle(2);
    `CHK(show.on, 1'b0)
    for (int k = 1; k <= 2; k++) begin
      wr(CTRL_OFF, 32'h07, RESP_OKAY);
      wr(COIL_OFF, 32'h000b, RESP_OKAY);
      settle(2);
      `CHK(show, 7'h30)
      settle(50);
      `CHK(show, 7'h30)
      press <= 2'(k);
      settle(8);
      press <= 2'd0;
      `CHK(show.on, 1'b0)
      rd(CTRL_OFF, 32'h05, RESP_OKAY);
    end
    wr(COIL_OFF, 32'h0, RESP_OKAY);
  endtask

  task automatic t_retain;
    wr(RETAIN_OFF, 32'h02, RESP_OKAY);
    wr(CTRL_OFF, 32'h07, RESP_OKAY);
    wr(COIL_OFF, 32'h0106, RESP_OKAY);
    settle(2);
    `CHK(show.rotating, 1'b1)
    wr(CTRL_OFF, 32'h06, RESP_OKAY);
    settle(3);
    `CHK(contact, 16'h0002)
    `CHK(show.on, 1'b0)
    wr(CTRL_OFF, 32'h07, RESP_OKAY);
    settle(3);
    `CHK(show, 7'h51)
    wr(CTRL_OFF, 32'h03, RESP_OKAY);
    settle(3);
    `CHK(contact, 16'h0002)
    `CHK(show.on, 1'b0)
    wr(CTRL_OFF, 32'h07, RESP_OKAY);
    wr(RETAIN_OFF, 32'h0, RESP_OKAY);
    wr(COIL_OFF, 32'h0, RESP_OKAY);
  endtask

  task automatic t_text;
    wr(TXT_ADDR_OFF, 32'(15 * TEXT_CHARS + 13), RESP_OKAY);
    wr(TXT_DATA_OFF, 32'h41, RESP_OKAY);
    wr(TXT_DATA_OFF, 32'h42, RESP_OKAY);
    wr(COIL_OFF, 32'h8000, RESP_OKAY);
    settle(2);
    `CHK(show, 7'h5f)
    want_pos <= 6'd13;
    settle(5);
    `CHK(seen_char, 8'h41)
    want_pos <= 6'd14;
    settle(5);
    `CHK(seen_char, 8'h42)
    want_pos <= 6'd48;
    settle(5);
    `CHK(seen_char, SPACE_CHAR)
    wr(SETPT_OFF, 32'h0001_0015, RESP_SLVERR);
    wr(CTRL_OFF, 32'h0f, RESP_OKAY);
    wr(SETPT_OFF, 32'h0001_0015, RESP_OKAY);
    `CHK(setpoint[20:0], 21'h1f_0015)
    wr(CTRL_OFF, 32'h07, RESP_OKAY);
    wr(COIL_OFF, 32'h0, RESP_OKAY);
    wr(SETPT_OFF, 32'h0001_0015, RESP_SLVERR);
    want_pos <= 6'd13;
    settle(5);
    `CHK(seen_char, SPACE_CHAR)
  endtask

  task automatic t_scale;
    logic signed [15:0] lo [3];
    logic signed [15:0] hi [3];
    lo = '{16'sh0, -16'sd999, -16'sd99};
    hi = '{16'sd9999, 16'sd999, 16'sd99};
    for (int m = 0; m < 3; m++) begin
      wr(CTRL_OFF, {26'h0, 2'(m), 4'h7}, RESP_OKAY);
      adc_value <= 10'h000;
      settle(3);
      `CHK(scaled_value, lo[m])
      adc_value <= 10'h3ff;
      settle(3);
      `CHK(scaled_value, hi[m])
    end
  endtask

  task automatic conclude;
    if (error_cnt == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    conclude();
  end

  // main sequence
  initial begin
    error_cnt = 0; checks_done = 0; aresetn = 1'b0;
    awaddr = '0; awvalid = 1'b0; wdata = '0; wstrb = '0; wvalid = 1'b0; bready = 1'b0;
    araddr = '0; arvalid = 1'b0; rready = 1'b0;
    adc_value = '0; want_pos = '0; press = '0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_gate();
    t_rotate();
    t_alarm();
    t_retain();
    t_text();
    t_scale();
    conclude();
  end
endmodule
